/* File: uc_channel.sv */
// Operation
// [RULE1] Divider makes 16x tick, sixteenth steps
// [RULE2] Divisor resets to low 01, high 00
// [RULE3] Prescaler bit slows rate by four
// [RULE4] Divisor is high byte over low
// [RULE5] Bit lasts sixteen ticks, both directions
// [RULE6] Start, data, optional parity, stop bits
// [RULE7] Least significant data bit first
// [RULE8] Queued writes push sixteen-byte queue
// [RULE9] Unqueued: holding-empty on move to shifter
// [RULE10] Holding-empty raises enabled transmit interrupt
// [RULE11] Unqueued: idle when shifter empty
// [RULE12] Queued: holding-empty tracks empty queue
// [RULE13] Queued: idle needs queue and shifter empty
// [RULE14] Start validated low after eight ticks
// [RULE15] Later bits sampled sixteen ticks apart
// [RULE16] Parity, framing, break shown status 2-4
// [RULE17] Receive queue holds byte plus tags
// [RULE18] Reading receive advances head, tags follow
// [RULE19] Queued receive holding shows oldest byte
// [RULE20] Data ready interrupt per byte or trigger
// [RULE21] Timeout after four chars plus twelve bits
// [RULE22] Host bus independent of divider
// [RULE23] Overrun drops new byte, keeps queue
`timescale 1ns/1ps
`include "uc_cfg.svh"

// Generic queue with valid/ready on both sides
module uc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clear,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];      // Storage array
  logic [AW-1:0]    wr_ptr_reg;       // Next write slot
  logic [AW-1:0]    rd_ptr_reg;       // Head slot
  logic [AW:0]      count_reg;        // Occupancy
  logic             push;
  logic             pop;

  // Pointer wrap needs a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("uc_fifo depth must be a power of two");
  end

  assign in_ready  = (count_reg < (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign count     = count_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// One serial channel with its host register port
module uc_channel #(
  parameter int DEPTH = 16
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_n,
  input  wire logic       rx_serial,
  output logic            tx_serial,
  output logic            irq,
  output logic            tx_full
);
  import uc_pkg::*;
  localparam int CW = $clog2(DEPTH) + 1;

  // Host pins pass two flops; first stage read only by second
  logic [13:0] bus_s1_reg, bus_s2_reg;
  logic [1:0]  rx_s_reg;
  logic        rx_prev_reg;            // Edge detect on settled line
  logic        rd_act, wr_act, rd_prev_reg, wr_prev_reg;
  logic [2:0]  bus_addr_reg;           // Address held during a cycle
  logic [7:0]  bus_data_reg;           // Write data held during a cycle
  logic        rd_end, wr_end;

  // Programmer visible registers
  logic [7:0]  div_lo_reg, div_hi_reg, lcr_reg, mcr_reg, ier_reg, frac_reg;
  logic [7:0]  fcr_reg;
  logic        overrun_reg;            // Sticky, cleared by status read
  logic        txe_pend_reg;           // Transmit empty interrupt pending
  logic        tmo_pend_reg;           // Receive timeout pending

  // Divider state
  logic [1:0]  presc_reg;
  logic [15:0] div_cnt_reg;
  logic [3:0]  frac_acc_reg;
  logic        stretch_reg;            // One extra count owed by fraction
  logic        tick_reg;               // 16x sampling enable
  logic        presc_en;
  logic [15:0] divisor;

  // Queues
  logic        tx_push, tx_ready, tx_valid, tx_pop, tx_clr;
  logic [7:0]  tx_head;
  logic [CW-1:0] tx_cnt, rx_cnt;
  logic        rx_push, rx_ready, rx_valid, rx_pop, rx_clr;
  logic [10:0] rx_word, rx_head;

  // Sequencers
  uc_tx_state_e tx_state_reg;
  uc_rx_state_e rx_state_reg;
  logic [3:0]  tx_tick_reg, rx_tick_reg;
  logic [2:0]  tx_bit_reg, rx_bit_reg;
  logic [7:0]  tx_shift_reg, rx_shift_reg;
  logic        tx_stop2_reg, rx_par_err_reg;
  logic        tx_line_reg;
  logic [11:0] tmo_cnt_reg;
  logic [11:0] tmo_limit;
  logic [3:0]  char_bits;
  logic [4:0]  trig;
  logic        queued, rx_hit, tx_empty_now, tx_empty_prev_reg;
  logic [7:0]  line_status, interrupt_status, rd_val;

  assign queued = fcr_reg[`UC_FCR_EN];

  // Host pin synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_s1_reg <= 14'h3fff;
      bus_s2_reg <= 14'h3fff;
      rx_s_reg   <= 2'h3;
    end else begin
      bus_s1_reg <= {cs_n, rd_n, wr_n, addr, data_in};
      bus_s2_reg <= bus_s1_reg;
      rx_s_reg   <= {rx_s_reg[0], rx_serial};
    end
  end

  assign rd_act = !bus_s2_reg[13] && !bus_s2_reg[12];
  assign wr_act = !bus_s2_reg[13] && !bus_s2_reg[11];
  assign rd_end = rd_prev_reg && !rd_act;
  assign wr_end = wr_prev_reg && !wr_act;

  // Strobe tracking; effects land when a strobe ends
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_prev_reg  <= 1'b0;
      wr_prev_reg  <= 1'b0;
      bus_addr_reg <= 3'h0;
      bus_data_reg <= `UC_ZERO8;
    end else begin
      rd_prev_reg <= rd_act;
      wr_prev_reg <= wr_act;
      if (rd_act || wr_act) begin
        bus_addr_reg <= bus_s2_reg[10:8];
        bus_data_reg <= bus_s2_reg[7:0];
      end
    end
  end

  // [RULE2] Divisor reset value
  // [RULE22] Register writes need no divider tick
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_lo_reg <= `UC_DIVLO_RST;
      div_hi_reg <= `UC_DIVHI_RST;
      lcr_reg    <= `UC_ZERO8;
      mcr_reg    <= `UC_ZERO8;
      ier_reg    <= `UC_ZERO8;
      fcr_reg    <= `UC_ZERO8;
      frac_reg   <= `UC_ZERO8;
    end else if (wr_end) begin
      case (bus_addr_reg)
        `UC_OFS_HOLD: begin
          if (lcr_reg[`UC_LCR_DLAB]) div_lo_reg <= bus_data_reg;
        end
        `UC_OFS_IEN: begin
          if (lcr_reg[`UC_LCR_DLAB]) div_hi_reg <= bus_data_reg;
          else ier_reg <= bus_data_reg;
        end
        `UC_OFS_ISTAT: fcr_reg  <= bus_data_reg;
        `UC_OFS_LCTL:  lcr_reg  <= bus_data_reg;
        `UC_OFS_MCTL:  mcr_reg  <= bus_data_reg;
        `UC_OFS_DFRAC: frac_reg <= bus_data_reg;
        default: ;
      endcase
    end
  end

  // [RULE4] Integer divisor from both bytes
  assign divisor = {div_hi_reg, div_lo_reg};
  // [RULE3] Prescaler gives a quarter rate
  assign presc_en = !mcr_reg[`UC_MCR_PRESC] || (presc_reg == `UC_PRESC_LAST);

  // [RULE1] Divide with fractional stretch cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_reg    <= 2'h0;
      div_cnt_reg  <= 16'h0000;
      frac_acc_reg <= 4'h0;
      stretch_reg  <= 1'b0;
      tick_reg     <= 1'b0;
    end else begin
      presc_reg <= presc_reg + 2'h1;
      tick_reg  <= 1'b0;
      if (presc_en) begin
        // Zero divisor ticks on every enabled cycle, ignoring the fraction, rather than stalling
        if (div_cnt_reg + 16'h0001 >= divisor + {15'h0, stretch_reg}) begin
          div_cnt_reg <= 16'h0000;
          tick_reg    <= 1'b1;
          {stretch_reg, frac_acc_reg} <= {1'b0, frac_acc_reg} + {1'b0, frac_reg[3:0]};
        end else begin
          div_cnt_reg <= div_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // [RULE8] Host write pushes the transmit queue
  // [RULE9] Unqueued mode holds a single byte
  assign tx_push = wr_end && (bus_addr_reg == `UC_OFS_HOLD) && !lcr_reg[`UC_LCR_DLAB] &&
                   (queued || !tx_valid);
  assign tx_clr  = wr_end && (bus_addr_reg == `UC_OFS_ISTAT) &&
                   (bus_data_reg[`UC_FCR_TXRST] || bus_data_reg[`UC_FCR_EN] != queued);
  assign tx_pop  = (tx_state_reg == UC_TX_IDLE) && tx_valid;

  uc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .clear     (tx_clr),
    .in_valid  (tx_push),
    .in_ready  (tx_ready),
    .in_data   (bus_data_reg),
    .out_valid (tx_valid),
    .out_ready (tx_pop),
    .out_data  (tx_head),
    .count     (tx_cnt)
  );

  // [RULE6] Transmit frame sequencer
  // [RULE5] Every transmit bit spans sixteen ticks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_reg <= UC_TX_IDLE;
      tx_tick_reg  <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_shift_reg <= `UC_ZERO8;
      tx_stop2_reg <= 1'b0;
      tx_line_reg  <= 1'b1;
    end else begin
      case (tx_state_reg)
        UC_TX_IDLE: begin
          tx_line_reg <= 1'b1;
          if (tx_pop) begin
            tx_shift_reg <= tx_head;
            tx_tick_reg  <= 4'h0;
            tx_state_reg <= UC_TX_START;
          end
        end
        UC_TX_START: begin
          tx_line_reg <= 1'b0;
          if (tick_reg) begin
            tx_tick_reg <= tx_tick_reg + 4'h1;
            if (tx_tick_reg == `UC_TICKS_BIT) begin
              tx_bit_reg   <= 3'h0;
              tx_state_reg <= UC_TX_DATA;
            end
          end
        end
        UC_TX_DATA: begin
          // [RULE7] Bit zero goes out first
          tx_line_reg <= tx_shift_reg[tx_bit_reg];
          if (tick_reg) begin
            tx_tick_reg <= tx_tick_reg + 4'h1;
            if (tx_tick_reg == `UC_TICKS_BIT) begin
              tx_bit_reg <= tx_bit_reg + 3'h1;
              if (tx_bit_reg == 3'(`UC_WL_BASE) - 3'h1 + {1'b0, lcr_reg[1:0]}) begin
                tx_stop2_reg <= lcr_reg[`UC_LCR_STOP];
                tx_state_reg <= lcr_reg[`UC_LCR_PEN] ? UC_TX_PAR : UC_TX_STOP;
              end
            end
          end
        end
        UC_TX_PAR: begin
          tx_line_reg <= uc_parity(tx_shift_reg, lcr_reg[1:0], lcr_reg[`UC_LCR_EVEN],
                                   lcr_reg[`UC_LCR_STICK]);
          if (tick_reg) begin
            tx_tick_reg <= tx_tick_reg + 4'h1;
            if (tx_tick_reg == `UC_TICKS_BIT) tx_state_reg <= UC_TX_STOP;
          end
        end
        UC_TX_STOP: begin
          tx_line_reg <= 1'b1;
          if (tick_reg) begin
            tx_tick_reg <= tx_tick_reg + 4'h1;
            if (tx_tick_reg == `UC_TICKS_BIT) begin
              tx_stop2_reg <= 1'b0;
              if (!tx_stop2_reg) tx_state_reg <= UC_TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= UC_TX_IDLE;
      endcase
    end
  end

  // [RULE12] Holding-empty follows the queue
  assign tx_empty_now = !tx_valid;

  // [RULE10] Pending on the move to empty; set wins over clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_empty_prev_reg <= 1'b1;
      txe_pend_reg      <= 1'b0;
    end else begin
      tx_empty_prev_reg <= tx_empty_now;
      if (tx_empty_now && !tx_empty_prev_reg) begin
        txe_pend_reg <= 1'b1;
      end else if (tx_push || (rd_end && bus_addr_reg == `UC_OFS_ISTAT &&
                               interrupt_status[3:0] == `UC_ISR_TXEMP)) begin
        txe_pend_reg <= 1'b0;
      end
    end
  end

  // [RULE14] Falling edge starts the half-bit check
  // [RULE15] Centre sampling every sixteen ticks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_reg   <= UC_RX_IDLE;
      rx_prev_reg    <= 1'b1;
      rx_tick_reg    <= 4'h0;
      rx_bit_reg     <= 3'h0;
      rx_shift_reg   <= `UC_ZERO8;
      rx_par_err_reg <= 1'b0;
    end else begin
      rx_prev_reg <= rx_s_reg[1];
      case (rx_state_reg)
        UC_RX_IDLE: begin
          if (rx_prev_reg && !rx_s_reg[1]) begin
            rx_tick_reg  <= 4'h0;
            rx_state_reg <= UC_RX_START;
          end
        end
        UC_RX_START: begin
          if (tick_reg) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == `UC_TICKS_HALF) begin
              rx_tick_reg    <= 4'h0;
              rx_bit_reg     <= 3'h0;
              rx_shift_reg   <= `UC_ZERO8;
              rx_par_err_reg <= 1'b0;
              rx_state_reg   <= rx_s_reg[1] ? UC_RX_IDLE : UC_RX_DATA;
            end
          end
        end
        UC_RX_DATA: begin
          if (tick_reg) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == `UC_TICKS_BIT) begin
              rx_shift_reg[rx_bit_reg] <= rx_s_reg[1];
              rx_bit_reg <= rx_bit_reg + 3'h1;
              if (rx_bit_reg == 3'(`UC_WL_BASE) - 3'h1 + {1'b0, lcr_reg[1:0]}) begin
                rx_state_reg <= lcr_reg[`UC_LCR_PEN] ? UC_RX_PAR : UC_RX_STOP;
              end
            end
          end
        end
        UC_RX_PAR: begin
          if (tick_reg) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == `UC_TICKS_BIT) begin
              rx_par_err_reg <= rx_s_reg[1] != uc_parity(rx_shift_reg, lcr_reg[1:0],
                                   lcr_reg[`UC_LCR_EVEN], lcr_reg[`UC_LCR_STICK]);
              rx_state_reg <= UC_RX_STOP;
            end
          end
        end
        UC_RX_STOP: begin
          // Second stop bit is not checked; one is enough to frame
          if (tick_reg) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == `UC_TICKS_BIT) rx_state_reg <= UC_RX_IDLE;
          end
        end
        default: rx_state_reg <= UC_RX_IDLE;
      endcase
    end
  end

  // Character completes at the stop bit centre
  assign rx_hit = (rx_state_reg == UC_RX_STOP) && tick_reg && (rx_tick_reg == `UC_TICKS_BIT);
  // [RULE16] Tags: break, framing, parity
  // [RULE17] Byte stored with its three tags
  assign rx_word = {(!rx_s_reg[1] && rx_shift_reg == `UC_ZERO8), !rx_s_reg[1],
                    rx_par_err_reg, rx_shift_reg};
  // [RULE23] Full queue drops the new byte only
  assign rx_push = rx_hit && (queued || !rx_valid);
  // [RULE18] Host read of the holding register pops
  assign rx_pop  = rd_end && (bus_addr_reg == `UC_OFS_HOLD) && !lcr_reg[`UC_LCR_DLAB];
  assign rx_clr  = wr_end && (bus_addr_reg == `UC_OFS_ISTAT) &&
                   (bus_data_reg[`UC_FCR_RXRST] || bus_data_reg[`UC_FCR_EN] != queued);

  uc_fifo #(.WIDTH(11), .DEPTH(DEPTH)) u_rx_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .clear     (rx_clr),
    .in_valid  (rx_push),
    .in_ready  (rx_ready),
    .in_data   (rx_word),
    .out_valid (rx_valid),
    .out_ready (rx_pop),
    .out_data  (rx_head),
    .count     (rx_cnt)
  );

  // Overrun sticky; new overrun wins over status read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overrun_reg <= 1'b0;
    end else if (rx_hit && (!rx_ready || (!queued && rx_valid))) begin
      overrun_reg <= 1'b1;
    end else if (rd_end && bus_addr_reg == `UC_OFS_LSTAT) begin
      overrun_reg <= 1'b0;
    end
  end

  // [RULE21] Four characters plus twelve bits, in ticks
  assign char_bits = 4'h2 + `UC_WL_BASE + {2'h0, lcr_reg[1:0]} +
                     {3'h0, lcr_reg[`UC_LCR_PEN]} + {3'h0, lcr_reg[`UC_LCR_STOP]};
  assign tmo_limit = 12'((`UC_TMO_CHARS * {8'h00, char_bits} + `UC_TMO_BITS) * `UC_TMO_SCALE);

  // Timeout counter restarts on traffic; restart beats expiry
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tmo_cnt_reg  <= 12'h000;
      tmo_pend_reg <= 1'b0;
    end else if (rx_push || rx_pop || !rx_valid) begin
      tmo_cnt_reg  <= 12'h000;
      tmo_pend_reg <= 1'b0;
    end else if (tick_reg) begin
      if (tmo_cnt_reg == tmo_limit - 12'h001) tmo_pend_reg <= 1'b1;
      else tmo_cnt_reg <= tmo_cnt_reg + 12'h001;
    end
  end

  // [RULE20] Trigger level from queue control
  always_comb begin
    case (fcr_reg[7:6])
      2'h0:    trig = `UC_TRIG_0;
      2'h1:    trig = `UC_TRIG_1;
      2'h2:    trig = `UC_TRIG_2;
      default: trig = `UC_TRIG_3;
    endcase
  end

  // [RULE11] [RULE13] Idle needs queue and shifter empty
  assign line_status = {rx_valid && (rx_head[10:8] != 3'h0),
                tx_empty_now && (tx_state_reg == UC_TX_IDLE),
                tx_empty_now, rx_head[10:8] & {3{rx_valid}}, overrun_reg, rx_valid};

  // Interrupt priority: timeout, data ready, transmit empty
  always_comb begin
    interrupt_status = {queued, queued, 2'h0, `UC_ISR_NONE};
    if (ier_reg[`UC_IER_RX] && tmo_pend_reg) begin
      interrupt_status[3:0] = `UC_ISR_RXTMO;
    end else if (ier_reg[`UC_IER_RX] && rx_valid &&
                 (!queued || 5'(rx_cnt) >= trig)) begin
      interrupt_status[3:0] = `UC_ISR_RXRDY;
    end else if (ier_reg[`UC_IER_TX] && txe_pend_reg) begin
      interrupt_status[3:0] = `UC_ISR_TXEMP;
    end
  end

  // [RULE19] Holding register shows the queue head
  always_comb begin
    case (bus_s2_reg[10:8])
      `UC_OFS_HOLD:  rd_val = lcr_reg[`UC_LCR_DLAB] ? div_lo_reg : rx_head[7:0];
      `UC_OFS_IEN:   rd_val = lcr_reg[`UC_LCR_DLAB] ? div_hi_reg : ier_reg;
      `UC_OFS_ISTAT: rd_val = interrupt_status;
      `UC_OFS_LCTL:  rd_val = lcr_reg;
      `UC_OFS_MCTL:  rd_val = mcr_reg;
      `UC_OFS_LSTAT: rd_val = line_status;
      `UC_OFS_DFRAC: rd_val = frac_reg;
      default:       rd_val = `UC_ZERO8;
    endcase
  end

  // Output flops; data bus driven only during a read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out  <= `UC_ZERO8;
      data_oe_n <= 1'b1;
      tx_serial <= 1'b1;
      irq       <= 1'b0;
      tx_full   <= 1'b0;
    end else begin
      if (rd_act) data_out <= rd_val;
      data_oe_n <= !rd_act;
      tx_serial <= tx_line_reg && !lcr_reg[`UC_LCR_BRK];
      irq       <= (interrupt_status[3:0] != `UC_ISR_NONE);
      tx_full   <= !tx_ready || (!queued && tx_valid);
    end
  end
endmodule

/* File: uc_cfg.svh */
`ifndef UC_CFG_SVH
`define UC_CFG_SVH

// Register offsets on the three address lines
`define UC_OFS_HOLD      3'h0
`define UC_OFS_IEN       3'h1
`define UC_OFS_ISTAT     3'h2
`define UC_OFS_LCTL      3'h3
`define UC_OFS_MCTL      3'h4
`define UC_OFS_LSTAT     3'h5
`define UC_OFS_DFRAC     3'h7

// Reset values
`define UC_DIVLO_RST     8'h01
`define UC_DIVHI_RST     8'h00
`define UC_ZERO8         8'h00

// Field positions
`define UC_LCR_DLAB      7
`define UC_LCR_BRK       6
`define UC_LCR_STICK     5
`define UC_LCR_EVEN      4
`define UC_LCR_PEN       3
`define UC_LCR_STOP      2
`define UC_MCR_PRESC     7
`define UC_FCR_EN        0
`define UC_FCR_RXRST     1
`define UC_FCR_TXRST     2
`define UC_IER_RX        0
`define UC_IER_TX        1

// Interrupt status codes
`define UC_ISR_NONE      4'h1
`define UC_ISR_RXRDY     4'h4
`define UC_ISR_RXTMO     4'hc
`define UC_ISR_TXEMP     4'h2

// Timing counts
`define UC_TICKS_BIT     4'hf
`define UC_TICKS_HALF    4'h7
`define UC_PRESC_LAST    2'h3
`define UC_TMO_CHARS     12'h004
`define UC_TMO_BITS      12'h00c
`define UC_TMO_SCALE     12'h010
`define UC_WL_BASE       4'h5

// Receive trigger levels
`define UC_TRIG_0        5'h01
`define UC_TRIG_1        5'h04
`define UC_TRIG_2        5'h08
`define UC_TRIG_3        5'h0e

`endif

/* File: uc_pkg.sv */
package uc_pkg;
  // Transmit sequencer states
  typedef enum logic [4:0] {
    UC_TX_IDLE  = 5'h01,
    UC_TX_START = 5'h02,
    UC_TX_DATA  = 5'h04,
    UC_TX_PAR   = 5'h08,
    UC_TX_STOP  = 5'h10
  } uc_tx_state_e;

  // Receive sequencer states
  typedef enum logic [4:0] {
    UC_RX_IDLE  = 5'h01,
    UC_RX_START = 5'h02,
    UC_RX_DATA  = 5'h04,
    UC_RX_PAR   = 5'h08,
    UC_RX_STOP  = 5'h10
  } uc_rx_state_e;

  // Parity of a character masked to its word length
  function automatic logic uc_parity(input logic [7:0] data, input logic [1:0] wl,
                                     input logic even, input logic stick);
    logic [7:0] mask;
    mask = 8'hff >> (2'h3 - wl);
    if (stick) begin
      uc_parity = ~even;
    end else begin
      uc_parity = even ? ^(data & mask) : ~^(data & mask);
    end
  endfunction
endpackage

/* File: uc_channel_checker.sv */
`timescale 1ns/1ps
// Watches the host port and serial pins of one channel
module uc_channel_checker #(
  parameter int DEPTH = 16
) (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_n,
  input wire logic       rx_serial,
  input wire logic       tx_serial,
  input wire logic       irq,
  input wire logic       tx_full
);
  logic [3:0] wr_age; // Cycles since a write strobe, saturating
  // Age of the last write strobe at the pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_age <= 4'hf;
    end else if (!cs_n && !wr_n) begin
      wr_age <= 4'h0;
    end else if (wr_age != 4'hf) begin
      wr_age <= wr_age + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_read_answer: assert property ($fell(data_oe_n) |-> $past(!cs_n && !rd_n, 3))
    else $error("data bus driven without a read");
  a_read_drive: assert property ((!cs_n && !rd_n)[*4] |-> !data_oe_n)
    else $error("read not answered in three clocks");
  a_read_release: assert property (rd_n[*4] |-> data_oe_n)
    else $error("data bus held after read");
  a_oe_end: assert property ($rose(data_oe_n) |-> $past(rd_n || cs_n, 3))
    else $error("data bus released early");
  a_reset_quiet: assert property ($rose(reset_n) |-> (!irq && tx_serial && !tx_full)[*3])
    else $error("outputs not idle after reset");
  a_start_len: assert property ($fell(tx_serial) |-> !tx_serial[*8] ##1 !tx_serial[*8])
    else $error("low bit shorter than sixteen ticks");
  a_mark_len: assert property ($rose(tx_serial) |-> tx_serial[*8] ##1 tx_serial[*8])
    else $error("high bit shorter than sixteen ticks");
  a_full_cause: assert property ($rose(tx_full) |-> wr_age <= 4'h8)
    else $error("transmit queue filled without a write");
endmodule
bind uc_channel uc_channel_checker #(.DEPTH(DEPTH)) u_chk (.clk(clk), .reset_n(reset_n),
  .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
  .data_out(data_out), .data_oe_n(data_oe_n), .rx_serial(rx_serial),
  .tx_serial(tx_serial), .irq(irq), .tx_full(tx_full));

/* File: uc_serial_peer.sv */
`timescale 1ns/1ps
// Far serial device: sends frames and decodes what arrives, at divisor one
module uc_serial_peer (
  input  wire logic clk,
  output logic      line_out,
  input  wire logic line_in
);
  logic [7:0] got[$]; // Bytes decoded from the line
  logic [7:0] sh;     // Assembly register
  initial line_out = 1'b1;
  // Frame bits go out LSB first, sixteen clocks each
  task automatic send(input logic [10:0] bits, input int n);
    @(posedge clk);
    for (int k = 0; k < n; k++) begin
      #1 line_out = bits[k];
      repeat (16) @(posedge clk);
    end
    #1 line_out = 1'b1;
  endtask
  // Short low pulse that must not pass as a start bit
  task automatic glitch();
    @(posedge clk);
    #1 line_out = 1'b0;
    repeat (5) @(posedge clk);
    #1 line_out = 1'b1;
    repeat (40) @(posedge clk);
  endtask
  // Sample mid-bit after each falling edge, eight data bits
  always begin
    @(negedge line_in);
    repeat (8) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      repeat (16) @(posedge clk);
      sh[k] = line_in;
    end
    repeat (16) @(posedge clk);
    got.push_back(sh);
  end
endmodule

/* File: uc_channel_tb.sv */
`timescale 1ns/1ps
module uc_channel_tb;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       cs_n = 1'b1;
  logic       rd_n = 1'b1;
  logic       wr_n = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] data_in = 8'h00;
  logic [7:0] data_out, rd_val;
  logic       data_oe_n, rx_serial, tx_serial, irq, tx_full;
  int         error_cnt = 0;
  int         tests_run = 0;
  int         i;
  logic [7:0] sent[$]; // Bytes the queue accepted
  always #5 clk = ~clk;
  uc_channel #(.DEPTH(16)) DUT (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .rx_serial(rx_serial), .tx_serial(tx_serial), .irq(irq),
    .tx_full(tx_full));
  uc_serial_peer peer (.clk(clk), .line_out(rx_serial), .line_in(tx_serial));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // One bus cycle: strobe held four clocks, then four clocks idle
  task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {addr, data_in, cs_n, wr_n, rd_n} = {a, d, 1'b0, ~wr, wr};
    repeat (4) @(posedge clk);
    #1 rd_val = data_out;
    {cs_n, wr_n, rd_n} = 3'b111;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    bus(1'b0, a, 8'h00);
    check(what, rd_val, exp);
  endtask
  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    #300000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    bus(1'b1, 3'h3, 8'h83);
    rd(3'h0, 8'h01, "divisor_low");
    rd(3'h1, 8'h00, "divisor_high");
    bus(1'b1, 3'h0, 8'h5a);
    rd(3'h0, 8'h5a, "divisor_low");
    bus(1'b1, 3'h0, 8'h01);
    bus(1'b1, 3'h3, 8'h03);
    rd(3'h6, 8'h00, "unmapped");
    rd(3'h5, 8'h60, "line_status");
    bus(1'b1, 3'h2, 8'h01);
    bus(1'b1, 3'h1, 8'h02);
    // Fill until refused; the shifter takes one byte early
    for (i = 0; i < 20 && !tx_full; i++) begin
      bus(1'b1, 3'h0, 8'(i * 17 + 3));
      sent.push_back(8'(i * 17 + 3));
    end
    check("tx_full", {7'h0, tx_full}, 8'h01);
    bus(1'b1, 3'h0, 8'hee);
    rd(3'h5, 8'h00, "line_status");
    for (i = 0; i < 4000 && !irq; i++) @(posedge clk);
    rd(3'h5, 8'h20, "line_status");
    rd(3'h2, 8'hc2, "interrupt_status");
    check("irq", {7'h0, irq}, 8'h00);
    repeat (200) @(posedge clk);
    rd(3'h5, 8'h60, "line_status");
    check("byte count", 8'(peer.got.size()), 8'(sent.size()));
    for (i = 0; i < sent.size(); i++) check("tx byte", peer.got[i], sent[i]);
    bus(1'b1, 3'h1, 8'h01);
    peer.glitch();
    peer.send({1'b1, 8'h96, 1'b0}, 10);
    peer.send({1'b1, 8'h0f, 1'b0}, 10);
    repeat (4) @(posedge clk);
    check("irq", {7'h0, irq}, 8'h01);
    rd(3'h2, 8'hc4, "interrupt_status");
    rd(3'h5, 8'h61, "line_status");
    rd(3'h0, 8'h96, "rx_holding");
    rd(3'h0, 8'h0f, "rx_holding");
    // Seventeen frames into sixteen slots; the last one is dropped
    for (i = 0; i < 17; i++) peer.send({1'b1, 8'(i), 1'b0}, 10);
    rd(3'h5, 8'h63, "line_status");
    rd(3'h0, 8'h00, "rx_holding");
    bus(1'b1, 3'h2, 8'h03);
    bus(1'b1, 3'h3, 8'h0b);
    peer.send({1'b1, ^8'h35, 8'h35, 1'b0}, 11);
    peer.send({1'b1, ~^8'h36, 8'h36, 1'b0}, 11);
    rd(3'h5, 8'he5, "line_status");
    rd(3'h0, 8'h35, "rx_holding");
    rd(3'h5, 8'h61, "line_status");
    // One byte left unread; timeout falls due 896 ticks after the pop
    repeat (800) @(posedge clk);
    rd(3'h2, 8'hc4, "interrupt_status");
    repeat (100) @(posedge clk);
    rd(3'h2, 8'hcc, "interrupt_status");
    rd(3'h0, 8'h36, "rx_holding");
    conclude();
  end
endmodule
